/* File: shared/lcs_pkg.sv */
package lcs_pkg;

  // time base
  localparam int LCS_CLK_NS = 20;
  localparam int LCS_MS_NS = 1000000;
  localparam int LCS_MS_CYCLES = LCS_MS_NS / LCS_CLK_NS;
  localparam int LCS_BLINK_MS = 100;
  localparam logic [6:0] LCS_BLINK_LAST = 7'(LCS_BLINK_MS - 1);

  // register byte addresses
  localparam logic [7:0] LCS_A_CTRL = 8'h00;
  localparam logic [7:0] LCS_A_NETP = 8'h04;
  localparam logic [7:0] LCS_A_WORDS = 8'h08;
  localparam logic [7:0] LCS_A_PERIOD = 8'h0C;
  localparam logic [7:0] LCS_A_MEAS = 8'h10;
  localparam logic [7:0] LCS_A_ERRLOG = 8'h14;
  localparam logic [7:0] LCS_A_ISTAT = 8'h18;
  localparam logic [7:0] LCS_A_IMASK = 8'h1C;

  // period formula coefficients in microseconds
  localparam logic [19:0] LCS_COAX_NODE_US = 20'h00055;
  localparam logic [19:0] LCS_COAX_FRAME_US = 20'h0028E;
  localparam logic [19:0] LCS_POLL_US = 20'h002EE;
  localparam logic [19:0] LCS_COAX_LINK_US = 20'h00038;
  localparam logic [19:0] LCS_WORD_US = 20'h0000A;
  localparam logic [19:0] LCS_FIXED_US = 20'h0052A;
  localparam logic [19:0] LCS_OPT_FRAME_US = 20'h00302;
  localparam logic [19:0] LCS_HALF_MS_US = 20'h001F4;
  localparam logic [19:0] LCS_MS_US = 20'h003E8;
  localparam logic [19:0] LCS_MAX_PERIOD_US = 20'h3E418;

  localparam logic [7:0] LCS_CONST_MIN = 8'h05;
  localparam logic [7:0] LCS_PERIOD_MAX = 8'hFF;
  localparam logic [15:0] LCS_ERR_SHORT_CODE = 16'h021D;
  localparam logic [7:0] LCS_COAX_AUTO_MIN = 8'h11;
  localparam logic [7:0] LCS_COAX_AUTO_MAX = 8'h13;
  localparam logic [7:0] LCS_OPT_AUTO_MIN = 8'h14;
  localparam logic [7:0] LCS_OPT_AUTO_MAX = 8'h16;

  // auto-table periods, index node_code*3 + area (0 both, 1 io only, 2 memory only)
  localparam logic [7:0] LCS_COAX_TBL [0:11] = '{8'h13, 8'h11, 8'h12, 8'h13, 8'h11, 8'h12,
                                                 8'h13, 8'h12, 8'h12, 8'h13, 8'h12, 8'h13};
  localparam logic [7:0] LCS_OPT_TBL [0:11] = '{8'h15, 8'h14, 8'h15, 8'h16, 8'h14, 8'h15,
                                                8'h16, 8'h15, 8'h15, 8'h16, 8'h15, 8'h16};

  // interrupt status bits
  localparam int LCS_IRQ_SHORT = 0;
  localparam int LCS_IRQ_NEWMAX = 1;
  localparam int LCS_IRQ_W = 2;

  typedef struct packed {
    logic clear_max;
    logic [6:0] rsv_hi;
    logic [7:0] const_period;
    logic [5:0] rsv_mid;
    logic [1:0] node_code;
    logic rsv_lo;
    logic memory_link_area;
    logic io_link_area;
    logic startup;
    logic optical;
    logic manual_tables;
    logic ext_src;
    logic run;
  } lcs_ctrl_s;

  typedef struct packed {
    logic [1:0] rsv3;
    logic [5:0] link_units;
    logic [1:0] rsv2;
    logic [5:0] polled;
    logic [7:0] frames;
    logic [1:0] rsv1;
    logic [5:0] max_node;
  } lcs_netp_s;

  localparam lcs_ctrl_s LCS_CTRL_RST = '0;
  localparam lcs_netp_s LCS_NETP_RST = '{rsv3: 2'h0, link_units: 6'h00, rsv2: 2'h0, polled: 6'h04,
                                         frames: 8'h0A, rsv1: 2'h0, max_node: 6'h3E};
  localparam logic [11:0] LCS_WORDS_RST = 12'h000;

  typedef enum logic [1:0] {LCS_IDLE, LCS_RUN, LCS_HALT} lcs_state_e;

endpackage : lcs_pkg

/* File: hw/lcs_scheduler.sv */
// How it works
// - cycle period ignores message traffic entirely
// - period source: automatic default or manual
// - coax auto tables give 17-19 ms
// - optical auto tables give 20-22 ms
// - constant period 5..255 ms held fixed
// - otherwise formula, rounded to nearest ms
// - coax adds node, frame, polled terms
// - coax adds link unit, word, fixed terms
// - optical adds frame, polled, word, fixed
// - measure present and maximum cycle time
// - too short blinks indicator every 100 ms
// - too short logs 021D with minimum
// - too short node stays off link
module lcs_scheduler #(
  parameter logic [15:0] MS_CYCLES = 16'(lcs_pkg::LCS_MS_CYCLES)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  output logic cycle_start,
  output logic link_status_indicator,
  output logic link_member,
  output logic link_activate
);
  import lcs_pkg::*;

  lcs_ctrl_s ctrl;
  lcs_netp_s netp;
  logic [11:0] words;
  logic [LCS_IRQ_W-1:0] istat;
  logic [LCS_IRQ_W-1:0] imask;
  logic [LCS_IRQ_W-1:0] ievent;
  logic [15:0] ms_div;
  logic ms_tick;
  logic [19:0] sum_us;
  logic [19:0] next_sum_us;
  logic [7:0] min_ms;
  logic [7:0] sel_period;
  logic [3:0] tbl_idx;
  logic too_short;
  logic too_short_q;
  lcs_state_e state;
  logic [7:0] cyc_left;
  logic [7:0] run_period;
  logic [7:0] elapsed;
  logic [7:0] meas_present;
  logic [7:0] meas_max;
  logic new_max;
  logic [6:0] blink_cnt;
  logic [15:0] err_code;
  logic [7:0] err_set;
  logic [7:0] err_min;

  // register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= LCS_CTRL_RST;
      netp <= LCS_NETP_RST;
      words <= LCS_WORDS_RST;
      imask <= '0;
    end else begin
      ctrl.clear_max <= 1'b0;
      if (wr) begin
        unique case (addr)
          LCS_A_CTRL: ctrl <= lcs_ctrl_s'(wdata);
          LCS_A_NETP: netp <= lcs_netp_s'(wdata);
          LCS_A_WORDS: words <= wdata[11:0];
          LCS_A_IMASK: imask <= wdata[LCS_IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        LCS_A_CTRL: rdata <= {1'b0, 7'h00, ctrl.const_period, 6'h00, ctrl.node_code, 1'b0,
                              ctrl.memory_link_area, ctrl.io_link_area, ctrl.startup, ctrl.optical,
                              ctrl.manual_tables, ctrl.ext_src, ctrl.run};
        LCS_A_NETP: rdata <= {2'h0, netp.link_units, 2'h0, netp.polled, netp.frames, 2'h0, netp.max_node};
        LCS_A_WORDS: rdata <= {20'h00000, words};
        LCS_A_PERIOD: rdata <= {16'h0000, min_ms, sel_period};
        LCS_A_MEAS: rdata <= {16'h0000, meas_max, meas_present};
        LCS_A_ERRLOG: rdata <= {err_code, err_set, err_min};
        LCS_A_ISTAT: rdata <= {{(32-LCS_IRQ_W){1'b0}}, istat};
        LCS_A_IMASK: rdata <= {{(32-LCS_IRQ_W){1'b0}}, imask};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // sticky status, cleared by reading it; a same-cycle event wins
  assign ievent = {new_max, too_short && !too_short_q};

  always_ff @(posedge mclk) begin
    if (rst) begin
      istat <= '0;
    end else if (rd && addr == LCS_A_ISTAT) begin
      istat <= ievent;
    end else begin
      istat <= istat | ievent;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat & imask);
    end
  end

  // free-running millisecond time base
  always_ff @(posedge mclk) begin
    if (rst) begin
      ms_div <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_div == MS_CYCLES - 16'h0001);
      ms_div <= (ms_div == MS_CYCLES - 16'h0001) ? 16'h0000 : ms_div + 16'h0001;
    end
  end

  // period formula in microseconds; the optical node term is left out
  always_comb begin
    if (ctrl.optical) begin
      next_sum_us = 20'(20'(netp.frames) * LCS_OPT_FRAME_US)
                  + 20'(20'(netp.polled) * LCS_POLL_US)
                  + 20'(20'(words) * LCS_WORD_US)
                  + LCS_FIXED_US;
    end else begin
      next_sum_us = 20'(20'(netp.max_node) * LCS_COAX_NODE_US)
                  + 20'(20'(netp.frames) * LCS_COAX_FRAME_US)
                  + 20'(20'(netp.polled) * LCS_POLL_US)
                  + 20'(20'(netp.link_units) * LCS_COAX_LINK_US)
                  + 20'(20'(words) * LCS_WORD_US)
                  + LCS_FIXED_US;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sum_us <= LCS_FIXED_US;
      min_ms <= LCS_CONST_MIN;
    end else begin
      sum_us <= next_sum_us;
      if (sum_us >= LCS_MAX_PERIOD_US) begin
        min_ms <= LCS_PERIOD_MAX;
      end else begin
        min_ms <= 8'((sum_us + LCS_HALF_MS_US) / LCS_MS_US);
      end
    end
  end

  // period source selection
  always_comb begin
    tbl_idx = {2'b00, ctrl.node_code} * 4'h3
            + ((ctrl.io_link_area && !ctrl.memory_link_area) ? 4'h1 : 4'h0)
            + ((ctrl.memory_link_area && !ctrl.io_link_area) ? 4'h2 : 4'h0);
    if (!ctrl.manual_tables) begin
      sel_period = ctrl.optical ? LCS_OPT_TBL[tbl_idx] : LCS_COAX_TBL[tbl_idx];
    end else if (ctrl.ext_src) begin
      sel_period = ctrl.const_period;
    end else begin
      sel_period = min_ms;
    end
  end

  // a constant under 5 ms or under the computed minimum is refused
  assign too_short = ctrl.manual_tables && ctrl.ext_src &&
                     (ctrl.const_period < LCS_CONST_MIN || ctrl.const_period < min_ms);

  always_ff @(posedge mclk) begin
    if (rst) begin
      too_short_q <= 1'b0;
    end else begin
      too_short_q <= too_short;
    end
  end

  // error log keeps the latest too-short event
  always_ff @(posedge mclk) begin
    if (rst) begin
      err_code <= '0;
      err_set <= '0;
      err_min <= '0;
    end else if (too_short && !too_short_q) begin
      err_code <= LCS_ERR_SHORT_CODE;
      err_set <= ctrl.const_period;
      err_min <= min_ms;
    end
  end

  // cycle scheduler; no message activity enters it, so the period stays fixed
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= LCS_IDLE;
      cyc_left <= '0;
      run_period <= '0;
      cycle_start <= 1'b0;
    end else begin
      cycle_start <= 1'b0;
      unique case (state)
        LCS_IDLE: begin
          if (ctrl.run && too_short) begin
            state <= LCS_HALT;
          end else if (ctrl.run) begin
            state <= LCS_RUN;
            cyc_left <= sel_period;
            run_period <= sel_period;
            cycle_start <= 1'b1;
          end
        end
        LCS_RUN: begin
          if (!ctrl.run) begin
            state <= LCS_IDLE;
          end else if (too_short) begin
            state <= LCS_HALT;
          end else if (ms_tick) begin
            if (cyc_left <= 8'h01) begin
              cyc_left <= sel_period;
              run_period <= sel_period;
              cycle_start <= 1'b1;
            end else begin
              cyc_left <= cyc_left - 8'h01;
            end
          end
        end
        LCS_HALT: begin
          if (!ctrl.run || !too_short) begin
            state <= LCS_IDLE;
          end
        end
      endcase
    end
  end

  // cycle time measurement
  always_ff @(posedge mclk) begin
    if (rst) begin
      elapsed <= '0;
      meas_present <= '0;
    end else if (state != LCS_RUN) begin
      elapsed <= '0;
    end else if (ms_tick && cyc_left <= 8'h01) begin
      meas_present <= (elapsed == LCS_PERIOD_MAX) ? LCS_PERIOD_MAX : elapsed + 8'h01;
      elapsed <= '0;
    end else if (ms_tick && elapsed != LCS_PERIOD_MAX) begin
      elapsed <= elapsed + 8'h01;
    end
  end

  assign new_max = meas_present > meas_max;

  always_ff @(posedge mclk) begin
    if (rst || ctrl.clear_max) begin
      meas_max <= '0;
    end else if (new_max) begin
      meas_max <= meas_present;
    end
  end

  // indicator: steady on while linked, fast blink when refused
  always_ff @(posedge mclk) begin
    if (rst) begin
      blink_cnt <= '0;
      link_status_indicator <= 1'b0;
    end else if (state == LCS_HALT) begin
      if (ms_tick) begin
        blink_cnt <= (blink_cnt == LCS_BLINK_LAST) ? 7'h00 : blink_cnt + 7'h01;
        if (blink_cnt == LCS_BLINK_LAST) begin
          link_status_indicator <= !link_status_indicator;
        end
      end
    end else begin
      blink_cnt <= '0;
      link_status_indicator <= (state == LCS_RUN);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      link_member <= 1'b0;
      link_activate <= 1'b0;
    end else begin
      link_member <= (state == LCS_RUN);
      link_activate <= (state == LCS_RUN) && ctrl.startup;
    end
  end

  // checks
  tick_reload_a: assert property (@(posedge mclk) disable iff (rst)
    (state == LCS_RUN && ctrl.run && !too_short && ms_tick && cyc_left == 8'h01)
    |=> cycle_start && cyc_left == $past(sel_period))
    else $error("cycle boundary missed or not reloaded");

  const_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (ctrl.manual_tables && ctrl.ext_src && !too_short) |-> sel_period == ctrl.const_period
      && sel_period >= LCS_CONST_MIN)
    else $error("constant period not applied");

  formula_sel_a: assert property (@(posedge mclk) disable iff (rst)
    (ctrl.manual_tables && !ctrl.ext_src) |-> sel_period == min_ms)
    else $error("computed period not applied");

  coax_table_a: assert property (@(posedge mclk) disable iff (rst)
    (!ctrl.manual_tables && !ctrl.optical) |-> sel_period >= LCS_COAX_AUTO_MIN
      && sel_period <= LCS_COAX_AUTO_MAX)
    else $error("coax table period out of range");

  opt_table_a: assert property (@(posedge mclk) disable iff (rst)
    (!ctrl.manual_tables && ctrl.optical) |-> sel_period >= LCS_OPT_AUTO_MIN
      && sel_period <= LCS_OPT_AUTO_MAX)
    else $error("optical table period out of range");

  err_log_a: assert property (@(posedge mclk) disable iff (rst)
    (too_short && !too_short_q) |=> err_code == LCS_ERR_SHORT_CODE && err_min == $past(min_ms)
      && istat[LCS_IRQ_SHORT])
    else $error("too-short event not logged");

  off_link_a: assert property (@(posedge mclk) disable iff (rst)
    (too_short && ctrl.run) [*3] |-> !link_member && !link_activate)
    else $error("refused node still on link");

  blink_rate_a: assert property (@(posedge mclk) disable iff (rst)
    (state == LCS_HALT && $past(state) == LCS_HALT && $changed(link_status_indicator))
      |-> $past(blink_cnt) == LCS_BLINK_LAST && $past(ms_tick))
    else $error("indicator toggled off the 100 ms grid");

  max_track_a: assert property (@(posedge mclk) disable iff (rst || ctrl.clear_max)
    $changed(meas_present) |=> meas_max >= $past(meas_present))
    else $error("maximum below present cycle time");

  fixed_period_a: assert property (@(posedge mclk) disable iff (rst)
    (state == LCS_RUN && $past(state) == LCS_RUN && $changed(meas_present))
      |-> meas_present == $past(run_period) || meas_present == LCS_PERIOD_MAX)
    else $error("measured period differs from selected");

endmodule : lcs_scheduler

/* File: dv/lcs_link_node.sv */
// far-side link node: times the gap between cycle boundaries it is handed
module lcs_link_node (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cycle_start,
  output logic [31:0] gap,
  output logic [15:0] starts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt;

  // clocks from one boundary to the next, counted at the pulse itself
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt <= '0;
      gap <= '0;
      starts <= '0;
    end else if (cycle_start) begin
      gap <= cnt + 32'h1;
      cnt <= '0;
      starts <= starts + 16'h1;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
endmodule : lcs_link_node

/* File: dv/lcs_scheduler_tb.sv */
module lcs_scheduler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lcs_pkg::*;
  logic mclk, rst, wr, rd, irq, cycle_start, link_status_indicator, link_member, link_activate;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, gap, d;
  logic [15:0] starts, s0;
  int bad_count, checked, cyc, k;
  // expected auto periods, index nodes*3 + area column (both, io only, memory only)
  logic [7:0] coax_t [12] = '{8'h13, 8'h11, 8'h12, 8'h13, 8'h11, 8'h12, 8'h13, 8'h12, 8'h12, 8'h13, 8'h12, 8'h13};
  logic [7:0] opt_t [12] = '{8'h15, 8'h14, 8'h15, 8'h16, 8'h14, 8'h15, 8'h16, 8'h15, 8'h15, 8'h16, 8'h15, 8'h16};

  lcs_scheduler #(.MS_CYCLES(16'h000A)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .cycle_start(cycle_start), .link_status_indicator(link_status_indicator),
    .link_member(link_member), .link_activate(link_activate));
  lcs_link_node node (.mclk(mclk), .rst(rst), .cycle_start(cycle_start), .gap(gap), .starts(starts));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // run should take about 4300 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // write, then let the formula pipeline settle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  // clocks until the indicator next changes
  task automatic wait_toggle(output int n);
    logic s;
    s = link_status_indicator;
    n = 0;
    while (link_status_indicator === s && n < 3000) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 3000)
      bad_count++;
  endtask : wait_toggle

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    bad_count = 0;
    checked = 0;
    cyc = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(LCS_A_CTRL, d);
    check(d, 32'h0);
    rd_reg(LCS_A_NETP, d);
    check(d, 32'h00040A3E);
    rd_reg(LCS_A_WORDS, d);
    check(d, 32'h0);
    rd_reg(8'h20, d);
    check(d, 32'h0);
    wr_reg(LCS_A_PERIOD, 32'hFFFFFFFF);
    rd_reg(LCS_A_PERIOD, d);
    check(d, 32'h00001013);
    check(32'({cycle_start, link_member, link_activate}), 32'h0);
    $display("test registers done");
    for (int o = 0; o < 2; o++)
      for (int n = 0; n < 4; n++)
        for (int r = 0; r < 3; r++) begin
          wr_reg(LCS_A_CTRL, 32'((o << 3) | (n << 8)) | (r == 1 ? 32'h20 : 32'h0) | (r == 2 ? 32'h40 : 32'h0));
          rd_reg(LCS_A_PERIOD, d);
          check(32'(d[7:0]), 32'(o ? opt_t[n * 3 + r] : coax_t[n * 3 + r]));
        end
    $display("test auto tables done");
    wr_reg(LCS_A_NETP, 32'h08040A3E);
    wr_reg(LCS_A_WORDS, 32'h000000C0);
    wr_reg(LCS_A_CTRL, 32'h00000004);
    rd_reg(LCS_A_PERIOD, d);
    check(d, 32'h00001313);
    wr_reg(LCS_A_CTRL, 32'h0000000C);
    rd_reg(LCS_A_PERIOD, d);
    check(d, 32'h00000E0E);
    $display("test formula done");
    wr_reg(LCS_A_IMASK, 32'h00000003);
    wr_reg(LCS_A_CTRL, 32'h00000031);
    idle(530);
    check(gap, 32'd170);
    check(32'({link_member, link_activate, link_status_indicator}), 32'h7);
    rd_reg(LCS_A_MEAS, d);
    check(d, 32'h00001111);
    rd_reg(LCS_A_ISTAT, d);
    idle(2);
    check(32'(irq), 32'h0);
    $display("test auto run done");
    wr_reg(LCS_A_CTRL, 32'h001E0037);
    idle(790);
    check(gap, 32'd300);
    check(32'(irq), 32'h1);
    rd_reg(LCS_A_ISTAT, d);
    check(32'(d[LCS_IRQ_NEWMAX]), 32'h1);
    wr_reg(LCS_A_CTRL, 32'h00140037);
    idle(720);
    check(gap, 32'd200);
    rd_reg(LCS_A_MEAS, d);
    check(d, 32'h00001E14);
    $display("test constant period done");
    wr_reg(LCS_A_CTRL, 32'h00120037);
    idle(5);
    check(32'({link_member, link_activate}), 32'h0);
    rd_reg(LCS_A_ERRLOG, d);
    check(d, 32'h021D1213);
    check(32'(irq), 32'h1);
    rd_reg(LCS_A_ISTAT, d);
    check(32'(d[LCS_IRQ_SHORT]), 32'h1);
    s0 = starts;
    wait_toggle(k);
    wait_toggle(k);
    check(32'(k), 32'd1000);
    check(32'(starts), 32'(s0));
    wr_reg(LCS_A_CTRL, 32'h00130037);
    idle(10);
    check(32'({link_member, link_activate, link_status_indicator}), 32'h7);
    $display("test too short done");
    wr_reg(LCS_A_CTRL, 32'h80000000);
    rd_reg(LCS_A_CTRL, d);
    check(d, 32'h0);
    rd_reg(LCS_A_MEAS, d);
    check(d, 32'h00001414);
    idle(3);
    check(32'({link_member, link_activate}), 32'h0);
    $display("test stop done");
    wrap_up();
  end
endmodule : lcs_scheduler_tb
